// File: pkg/port_route_defines.svh
`ifndef PORT_ROUTE_DEFINES_SVH
`define PORT_ROUTE_DEFINES_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_DRIVE_SEL 12'h000
`define OFS_ROUTE_SEL 12'h004

// ************************************************************
// field positions
// ************************************************************
`define BIT_PORT_A_LOW 0
`define BIT_PORT_B_LOW 1
`define BIT_PORT_E_LOW 4
`define BIT_CH_ZERO 0
`define BIT_CH_FOUR 4
`define BIT_CH_FIVE 5

// ************************************************************
// writable masks and reset values
// ************************************************************
`define MASK_DRIVE_SEL 8'h13
`define MASK_ROUTE_SEL 8'h31
`define RST_DRIVE_SEL 8'h00
`define RST_ROUTE_SEL 8'h00

`endif

// File: pkg/port_route_pkg.sv
// ************************************************************
// shared types
// ************************************************************
package port_route_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [11:0] addr_t;
  typedef logic [31:0] word_t;
endpackage

// File: rtl/route_pin_pair.sv
`timescale 1ns/1ns
// ************************************************************
// one pulse channel steered to default or alternate pin
// ************************************************************
module route_pin_pair (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // control
  input wire logic i_to_alt,
  input wire logic i_pulse,
  // pins
  output logic o_default_pin,
  output logic o_default_en,
  output logic o_alt_pin,
  output logic o_alt_en
);
  // registered steering so each pin output comes from a flop
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_default_pin <= 1'b0;
      o_default_en <= 1'b0;
      o_alt_pin <= 1'b0;
      o_alt_en <= 1'b0;
    end else begin
      o_default_pin <= i_to_alt ? 1'b0 : i_pulse;
      o_default_en <= ~i_to_alt;
      o_alt_pin <= i_to_alt ? i_pulse : 1'b0;
      o_alt_en <= i_to_alt;
    end
  end
endmodule

// File: rtl/port_drive_and_pwm_routing.sv
// Notes on behaviour
// - drive-select bit 4 gives port E reduced drive when set, full when clear.
// - drive-select bit 1 gives port B reduced drive when set, full when clear.
// - drive-select bit 0 gives port A reduced drive when set, full when clear.
// - a set select drives outputs near one fifth strength, a clear one full strength.
// - a select has no effect on pins of its port configured as inputs.
// - the select applies whichever function owns the pin output.
// - routing bit 5 sends pulse channel five to alt pin five, else default pin five.
// - routing bit 4 sends pulse channel four to alt pin four, else default pin four.
// - routing bit 0 sends pulse channel zero to alt pin zero, else default pin zero.
`timescale 1ns/1ns
`include "port_route_defines.svh"
module port_drive_and_pwm_routing #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire port_route_pkg::addr_t i_paddr,
  input wire port_route_pkg::word_t i_pwdata,
  input wire logic [3:0] i_pstrb,
  output port_route_pkg::word_t o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // port output enables (1 = pin is output)
  input wire logic [PORT_W-1:0] i_port_a_dir,
  input wire logic [PORT_W-1:0] i_port_b_dir,
  input wire logic [PORT_W-1:0] i_port_e_dir,
  // per-pin reduced drive controls to pad cells
  output logic [PORT_W-1:0] o_port_a_low_drive,
  output logic [PORT_W-1:0] o_port_b_low_drive,
  output logic [PORT_W-1:0] o_port_e_low_drive,
  // pulse channels in
  input wire logic i_pulse_channel_zero,
  input wire logic i_pulse_channel_four,
  input wire logic i_pulse_channel_five,
  // routed pins
  output logic [2:0] o_default_pin,
  output logic [2:0] o_default_pin_en,
  output logic [2:0] o_alt_pin,
  output logic [2:0] o_alt_pin_en
);
  import port_route_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  reg8_t port_drive_strength_select;
  reg8_t pwm_pin_routing_select;
  logic access;
  logic wr_ok;
  logic hit_drive;
  logic hit_route;
  logic [2:0] ch_in;
  logic [2:0] ch_alt;

  assign access = i_psel & i_penable;
  assign hit_drive = (i_paddr == `OFS_DRIVE_SEL);
  assign hit_route = (i_paddr == `OFS_ROUTE_SEL);
  assign wr_ok = access & i_pwrite & i_pstrb[0];

  // software writes, undocumented bits masked off
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      port_drive_strength_select <= `RST_DRIVE_SEL;
      pwm_pin_routing_select <= `RST_ROUTE_SEL;
    end else if (wr_ok) begin
      if (hit_drive) begin
        port_drive_strength_select <= i_pwdata[7:0] & `MASK_DRIVE_SEL;
      end
      if (hit_route) begin
        pwm_pin_routing_select <= i_pwdata[7:0] & `MASK_ROUTE_SEL;
      end
    end
  end

  // zero-wait answer; unmapped address gives error and zero data
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~(hit_drive | hit_route);
      if (i_psel & ~i_penable & ~i_pwrite & hit_drive) begin
        o_prdata <= {24'h000000, port_drive_strength_select};
      end else if (i_psel & ~i_penable & ~i_pwrite & hit_route) begin
        o_prdata <= {24'h000000, pwm_pin_routing_select};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // drive strength, gated by pin direction only
  // ************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_port_a_low_drive <= '0;
      o_port_b_low_drive <= '0;
      o_port_e_low_drive <= '0;
    end else begin
      o_port_a_low_drive <= {PORT_W{port_drive_strength_select[`BIT_PORT_A_LOW]}}
                            & i_port_a_dir;
      o_port_b_low_drive <= {PORT_W{port_drive_strength_select[`BIT_PORT_B_LOW]}}
                            & i_port_b_dir;
      o_port_e_low_drive <= {PORT_W{port_drive_strength_select[`BIT_PORT_E_LOW]}}
                            & i_port_e_dir;
    end
  end

  // ************************************************************
  // pulse channel routing, index 0/1/2 = channel zero/four/five
  // ************************************************************
  assign ch_in = {i_pulse_channel_five, i_pulse_channel_four, i_pulse_channel_zero};
  assign ch_alt = {pwm_pin_routing_select[`BIT_CH_FIVE],
                   pwm_pin_routing_select[`BIT_CH_FOUR],
                   pwm_pin_routing_select[`BIT_CH_ZERO]};

  for (genvar g = 0; g < 3; g++) begin : g_route
    route_pin_pair u_pair (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_to_alt(ch_alt[g]),
      .i_pulse(ch_in[g]),
      .o_default_pin(o_default_pin[g]),
      .o_default_en(o_default_pin_en[g]),
      .o_alt_pin(o_alt_pin[g]),
      .o_alt_en(o_alt_pin_en[g])
    );
  end

  // ************************************************************
  // assertions
  // ************************************************************
  port_e_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_port_e_low_drive == ({PORT_W{$past(port_drive_strength_select[4])}} & $past(i_port_e_dir)))
    else $error("port e drive wrong");
  port_b_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_port_b_low_drive == ({PORT_W{$past(port_drive_strength_select[1])}} & $past(i_port_b_dir)))
    else $error("port b drive wrong");
  port_a_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 o_port_a_low_drive == ({PORT_W{$past(port_drive_strength_select[0])}} & $past(i_port_a_dir)))
    else $error("port a drive wrong");
  full_drive_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !port_drive_strength_select[0] |=> o_port_a_low_drive == '0)
    else $error("clear select not full drive");
  input_pin_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    ##1 (o_port_e_low_drive & ~$past(i_port_e_dir)) == '0)
    else $error("input pin affected");
  any_owner_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (port_drive_strength_select[1] && i_port_b_dir[0]) |=> o_port_b_low_drive[0])
    else $error("drive not applied");
  chan_five_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !i_rst |=> o_alt_pin_en[2] == $past(pwm_pin_routing_select[5])
    && o_default_pin_en[2] != o_alt_pin_en[2])
    else $error("channel five misrouted");
  chan_four_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    pwm_pin_routing_select[4] |=> o_alt_pin[1] == $past(i_pulse_channel_four) && !o_default_pin[1])
    else $error("channel four misrouted");
  chan_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !pwm_pin_routing_select[0] |=> o_default_pin[0] == $past(i_pulse_channel_zero) && !o_alt_pin[0])
    else $error("channel zero misrouted");
  reserved_zero_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (port_drive_strength_select & ~`MASK_DRIVE_SEL) == 8'h00
    && (pwm_pin_routing_select & ~`MASK_ROUTE_SEL) == 8'h00)
    else $error("reserved bit set");
  pready_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (i_psel && !i_penable) |=> o_pready)
    else $error("no ready after setup");

  drive_write_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    wr_ok && hit_drive);
  route_alt_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_alt_pin_en[2] && o_alt_pin[2]);
  bad_addr_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    o_pslverr);
endmodule

// File: testbench/port_drive_and_pwm_routing_tb_top.sv
`timescale 1ns/1ns
`include "port_route_defines.svh"
module port_drive_and_pwm_routing_tb_top;
  import port_route_pkg::*;
  typedef struct {logic rd; word_t data; logic err;} note_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  addr_t paddr = '0;
  word_t pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] dir_a = 8'h00, dir_b = 8'h00, dir_e = 8'h00;
  logic [2:0] pulse = 3'h0;
  word_t prdata;
  logic pready, pslverr;
  logic [7:0] low_a, low_b, low_e;
  logic [2:0] dpin, den, apin, aen;
  note_s notes[$];
  int n_errors = 0;
  int total_checks = 0;
  int seed = 12948;
  // ************************************************************
  // device under test
  // ************************************************************
  port_drive_and_pwm_routing u_dut (.i_clk_sys(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_port_a_dir(dir_a),
    .i_port_b_dir(dir_b), .i_port_e_dir(dir_e), .o_port_a_low_drive(low_a),
    .o_port_b_low_drive(low_b), .o_port_e_low_drive(low_e), .i_pulse_channel_zero(pulse[0]),
    .i_pulse_channel_four(pulse[1]), .i_pulse_channel_five(pulse[2]), .o_default_pin(dpin),
    .o_default_pin_en(den), .o_alt_pin(apin), .o_alt_pin_en(aen));
  // free running clock
  initial begin
    forever #2 clk = ~clk;
  end
  // ************************************************************
  // compare and verdict
  // ************************************************************
  task check_word(string what, word_t exp, word_t got);
    total_checks++;
    if (exp !== got) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task check_pins(string what, logic [7:0] exp, logic [7:0] got);
    total_checks++;
    if (exp !== got) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one apb transfer, entered right after a rising edge
  task apb(logic wr, addr_t a, word_t d, logic [3:0] s, word_t exp, logic err);
    int n;
    notes.push_back('{!wr, exp, err});
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_errors++;
      print_verdict;
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // monitor: oldest note against each bus answer
  always @(posedge clk) begin
    note_s e;
    if (psel && pen && pready === 1'b1 && notes.size() > 0) begin
      e = notes.pop_front();
      check_word("pslverr", {31'h0, e.err}, {31'h0, pslverr});
      if (e.rd) check_word("prdata", e.data, prdata);
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict;
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    word_t w;
    logic [2:0] r;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `OFS_DRIVE_SEL, '0, 4'hF, {24'h0, `RST_DRIVE_SEL}, 1'b0);
    apb(1'b0, `OFS_ROUTE_SEL, '0, 4'hF, {24'h0, `RST_ROUTE_SEL}, 1'b0);
    apb(1'b0, 12'h008, '0, 4'hF, '0, 1'b1);
    $display("test reset_and_map done");
    // every drive select combination with random pin directions
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      {w[4], w[1], w[0]} = i[2:0];
      apb(1'b1, `OFS_DRIVE_SEL, w, 4'hF, '0, 1'b0);
      apb(1'b0, `OFS_DRIVE_SEL, '0, 4'hF, w & {24'h0, `MASK_DRIVE_SEL}, 1'b0);
      dir_a <= $random(seed);
      dir_b <= $random(seed);
      dir_e <= $random(seed);
      repeat (2) @(posedge clk);
      check_pins("low_a", {8{w[0]}} & dir_a, low_a);
      check_pins("low_b", {8{w[1]}} & dir_b, low_b);
      check_pins("low_e", {8{w[4]}} & dir_e, low_e);
    end
    apb(1'b1, `OFS_DRIVE_SEL, 32'h0000_00FF, 4'h0, '0, 1'b0);
    apb(1'b0, `OFS_DRIVE_SEL, '0, 4'hF, w & {24'h0, `MASK_DRIVE_SEL}, 1'b0);
    $display("test drive_select done");
    // every routing combination with random pulse levels
    for (int i = 0; i < 8; i++) begin
      w = $random(seed);
      {w[5], w[4], w[0]} = i[2:0];
      r = i[2:0];
      apb(1'b1, `OFS_ROUTE_SEL, w, 4'hF, '0, 1'b0);
      apb(1'b0, `OFS_ROUTE_SEL, '0, 4'hF, w & {24'h0, `MASK_ROUTE_SEL}, 1'b0);
      pulse <= $random(seed);
      repeat (2) @(posedge clk);
      check_pins("alt_en", {5'h00, r}, {5'h00, aen});
      check_pins("default_en", {5'h00, ~r}, {5'h00, den});
      check_pins("alt_pin", {5'h00, pulse & r}, {5'h00, apin});
      check_pins("default_pin", {5'h00, pulse & ~r}, {5'h00, dpin});
    end
    $display("test pulse_routing done");
    print_verdict;
  end
endmodule
